// *** rtl/asc_ctrl.sv ***
// Host controller that runs read and write cycles on an asynchronous SRAM.
//
// Behaviour
// R1 - Write only while all four strobes active
// R2 - Time data against the terminating write edge
// R3 - Write pulse covers release plus data setup
// R4 - Address stable and valid through each cycle
// R5 - Device data valid after select access time
// R6 - Device lane data valid after lane access
// R7 - Device releases bus after output enable
// R8 - Device releases and drives bus around selects
// R9 - Device releases and drives lane around strobes
// R10 - Device stops driving when write strobe falls
// R11 - Device resumes driving after write strobe rises
// R12 - Selects active long enough before write end
// R13 - Write address leads write end enough
// R14 - Address held until the write ends
// R15 - Lane strobes active long enough before end
// R16 - Write data set up before write end
// R17 - Write data held to the terminating edge
// R18 - Width select low gives eight bit mode
// R19 - Read keeps write high, asserts enable, lanes
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_ctrl
#(
	parameter bit FAST_GRADE = 1'b1
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// User request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [20:0] req_addr,
	input  wire logic [15:0] req_wdata,
	input  wire logic [1:0]  req_lanes,
	input  wire logic        wide_mode,
	// User answer
	output logic             resp_valid,
	output logic [15:0]      resp_rdata,
	// SRAM control pins
	output logic [19:0]      addr_pin,
	output logic             select_low_n,
	output logic             select_high,
	output logic             upper_lane_n,
	output logic             lower_lane_n,
	output logic             write_n,
	output logic             out_en_n,
	output logic             width_sel,
	// SRAM data pins
	input  wire logic [15:0] dq_in,
	output logic [15:0]      dq_out,
	output logic [15:0]      dq_oe
);

	// -----------------------------------------------------------------
	// Cycle counts
	// -----------------------------------------------------------------
	// The data pins pass a two-stage synchroniser, so the read waits two
	// cycles beyond the access time before it samples.
	localparam int ACC_CYC = FAST_GRADE ? `ASC_CYC(`ASC_ACCESS_FAST_NS)
		: `ASC_CYC(`ASC_ACCESS_SLOW_NS);
	localparam int RC_CYC = FAST_GRADE
		? `ASC_CYC(`ASC_READ_CYCLE_PERIOD_FAST_NS)
		: `ASC_CYC(`ASC_READ_CYCLE_PERIOD_SLOW_NS);
	localparam int RD_CYC = (ACC_CYC + 2 > RC_CYC) ? ACC_CYC + 2 : RC_CYC;
	localparam int HZ_CYC = FAST_GRADE
		? `ASC_CYC(`ASC_OE_RELEASE_FAST_NS)
		: `ASC_CYC(`ASC_OE_RELEASE_SLOW_NS);
	localparam int WHZ_CYC = FAST_GRADE
		? `ASC_CYC(`ASC_WRITE_RELEASE_FAST_NS)
		: `ASC_CYC(`ASC_WRITE_RELEASE_SLOW_NS);
	localparam int SD_CYC = FAST_GRADE
		? `ASC_CYC(`ASC_WRITE_DATA_SETUP_FAST_NS)
		: `ASC_CYC(`ASC_WRITE_DATA_SETUP_SLOW_NS);
	localparam int PWE_MIN = FAST_GRADE
		? `ASC_CYC(`ASC_WRITE_PULSE_WIDTH_FAST_NS)
		: `ASC_CYC(`ASC_WRITE_PULSE_WIDTH_SLOW_NS);
	localparam int AW_CYC = FAST_GRADE
		? `ASC_CYC(`ASC_WRITE_ADDRESS_LEAD_FAST_NS)
		: `ASC_CYC(`ASC_WRITE_ADDRESS_LEAD_SLOW_NS);
	localparam int WC_CYC = FAST_GRADE
		? `ASC_CYC(`ASC_WRITE_CYCLE_PERIOD_FAST_NS)
		: `ASC_CYC(`ASC_WRITE_CYCLE_PERIOD_SLOW_NS);
	// Output enable stays high in writes, yet the pulse still covers the
	// release delay plus setup so the cycle is also legal with it low.
	localparam int PWE_CYC = (WHZ_CYC + SD_CYC > PWE_MIN)
		? WHZ_CYC + SD_CYC + 1 : PWE_MIN;
	localparam int WR_TOTAL = HZ_CYC + PWE_CYC + 1;
	localparam int TW = `ASC_TIMER_W;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed
	{
		asc_pkg::asc_state_type st;
		logic [19:0]            addr;
		logic                   extra;
		logic                   wide;
		logic [15:0]            wdata;
		logic [1:0]             lanes_n;
		logic                   sel;
		logic                   oe_n;
		logic                   we_n;
		logic                   drive;
		logic [15:0]            sync1;
		logic [15:0]            sync2;
		logic [15:0]            rdata;
		logic                   rvalid;
		logic [TW-1:0]          pad;
	} asc_state_vec_type;

	asc_state_vec_type s_q;
	asc_state_vec_type s_d;
	logic              t_load;
	logic [TW-1:0]     t_value;
	logic              t_done;

	asc_timer #(.WIDTH(TW)) u_timer
	(
		.clk   (clk),
		.rstn  (rstn),
		.load  (t_load),
		.value (t_value),
		.done  (t_done)
	);

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		t_load = 1'b0;
		t_value = '0;
		s_d.sync1 = dq_in;
		s_d.sync2 = s_q.sync1;
		s_d.rvalid = 1'b0;
		unique case (s_q.st)
			asc_pkg::ASC_IDLE:
			begin
				if (s_q.pad != '0)
					s_d.pad = s_q.pad - TW'(1);
				else if (req_valid)
				begin
					s_d.addr = req_addr[19:0];
					s_d.extra = req_addr[20];
					s_d.wide = wide_mode;
					s_d.wdata = req_wdata;
					// In eight bit mode the lanes are ignored; both are held
					// low so the write still meets the four-strobe overlap.
					s_d.lanes_n = (wide_mode == `ASC_WIDE_LEVEL)
						? ~req_lanes : 2'h0; // R18
					s_d.sel = 1'b1; // R4
					if (req_write)
					begin
						s_d.oe_n = 1'b1;
						t_load = 1'b1;
						t_value = TW'(HZ_CYC - 1); // R3
						s_d.st = asc_pkg::ASC_WSETUP;
					end
					else
					begin
						s_d.oe_n = 1'b0; // R19
						s_d.we_n = 1'b1; // R19
						t_load = 1'b1;
						t_value = TW'(RD_CYC - 1); // R5 R6
						s_d.st = asc_pkg::ASC_READ;
					end
				end
			end
			asc_pkg::ASC_READ:
			begin
				if (t_done)
				begin
					s_d.rdata = s_q.wide ? s_q.sync2
						: {8'h00, s_q.sync2[7:0]}; // R18
					s_d.rvalid = 1'b1;
					s_d.sel = 1'b0;
					s_d.oe_n = 1'b1;
					s_d.lanes_n = 2'h3;
					s_d.st = asc_pkg::ASC_IDLE;
				end
			end
			asc_pkg::ASC_WSETUP:
			begin
				// Waits out the device release before the host drives data.
				if (t_done)
				begin
					s_d.drive = 1'b1; // R7 R8 R9
					// With no lane enabled the strobe stays high: no write.
					s_d.we_n = &s_q.lanes_n; // R1
					t_load = 1'b1;
					t_value = TW'(PWE_CYC - 1); // R3 R12 R13 R15 R16
					s_d.st = asc_pkg::ASC_WPULSE;
				end
			end
			asc_pkg::ASC_WPULSE:
			begin
				if (t_done)
				begin
					s_d.we_n = 1'b1; // R2
					s_d.st = asc_pkg::ASC_WHOLD;
				end
			end
			asc_pkg::ASC_WHOLD:
			begin
				// Address, data and selects outlast the write edge by one
				// cycle, covering zero hold with board skew to spare.
				s_d.drive = 1'b0; // R14 R17
				s_d.sel = 1'b0;
				s_d.lanes_n = 2'h3;
				s_d.rvalid = 1'b1;
				s_d.pad = (WC_CYC > WR_TOTAL)
					? TW'(WC_CYC - WR_TOTAL) : '0;
				s_d.st = asc_pkg::ASC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.st <= asc_pkg::ASC_IDLE;
			s_q.lanes_n <= 2'h3;
			s_q.oe_n <= 1'b1;
			s_q.we_n <= 1'b1;
			s_q.wide <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// -----------------------------------------------------------------
	// Pins and answer
	// -----------------------------------------------------------------
	assign req_ready = (s_q.st == asc_pkg::ASC_IDLE) && (s_q.pad == '0);
	assign resp_valid = s_q.rvalid;
	assign resp_rdata = s_q.rdata;
	assign addr_pin = s_q.addr;
	assign select_low_n = ~s_q.sel;
	assign select_high = s_q.sel;
	assign upper_lane_n = s_q.lanes_n[1];
	assign lower_lane_n = s_q.lanes_n[0];
	assign write_n = s_q.we_n;
	assign out_en_n = s_q.oe_n;
	assign width_sel = s_q.wide;

	// In eight bit mode the top data line carries the extra address bit
	// for the whole cycle, read or write.
	always_comb
	begin
		dq_out = s_q.wdata;
		dq_oe = {16{s_q.drive}};
		if (!s_q.wide)
		begin
			dq_oe[14:8] = 7'h00; // R18
			dq_out[`ASC_EXTRA_ADDRESS_BIT] = s_q.extra; // R18
			dq_oe[`ASC_EXTRA_ADDRESS_BIT] = s_q.sel; // R18
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	logic [7:0] we_low_cnt;
	logic [7:0] sel_cnt;
	logic [7:0] drive_cnt;
	logic [7:0] oe_hi_cnt;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			we_low_cnt <= 8'h00;
			sel_cnt <= 8'h00;
			drive_cnt <= 8'h00;
			oe_hi_cnt <= 8'h00;
		end
		else
		begin
			we_low_cnt <= write_n ? 8'h00 : we_low_cnt + 8'h01;
			sel_cnt <= s_q.sel ? sel_cnt + 8'h01 : 8'h00;
			drive_cnt <= s_q.drive ? drive_cnt + 8'h01 : 8'h00;
			oe_hi_cnt <= !out_en_n ? 8'h00
				: oe_hi_cnt + 8'(oe_hi_cnt != 8'hff);
		end
	end

	a_write_overlap: assert property (@(posedge clk) disable iff (!rstn) // R1
		!write_n |-> !select_low_n && select_high
		&& !(upper_lane_n && lower_lane_n))
		else $error("write strobe low without all selects active");

	a_write_pulse: assert property (@(posedge clk) disable iff (!rstn) // R3
		$rose(write_n) |-> we_low_cnt >= 8'(PWE_CYC))
		else $error("write pulse shorter than required");

	a_select_lead: assert property (@(posedge clk) disable iff (!rstn) // R12
		$rose(write_n) |-> sel_cnt >= 8'(AW_CYC))
		else $error("selects not active long enough before write end");

	a_data_setup: assert property (@(posedge clk) disable iff (!rstn) // R16
		$rose(write_n) |-> drive_cnt >= 8'(SD_CYC))
		else $error("write data setup too short");

	a_hold_after: assert property (@(posedge clk) disable iff (!rstn) // R17
		$rose(write_n) |-> dq_oe[0] && $stable(dq_out) && $stable(addr_pin)
		&& !select_low_n ##1 !dq_oe[0] && select_low_n)
		else $error("data or address not held to the write end");

	a_addr_stable: assert property (@(posedge clk) disable iff (!rstn) // R4
		s_q.sel && $past(s_q.sel) |-> $stable(addr_pin))
		else $error("address moved inside a cycle");

	a_edge_owner: assert property (@(posedge clk) disable iff (!rstn) // R2
		!write_n && $past(!write_n) |-> $stable({upper_lane_n,
		lower_lane_n, select_low_n}))
		else $error("write ended by an edge other than the write strobe");

	a_read_levels: assert property (@(posedge clk) disable iff (!rstn) // R19
		!out_en_n |-> write_n && !select_low_n && select_high
		&& !dq_oe[0])
		else $error("read with bad control levels");

	a_bus_release: assert property (@(posedge clk) disable iff (!rstn) // R3
		$rose(dq_oe[0]) |-> oe_hi_cnt >= 8'(HZ_CYC))
		else $error("host drove data before device release");

	a_read_length: assert property (@(posedge clk) disable iff (!rstn) // R5
		$rose(out_en_n) |-> sel_cnt >= 8'(ACC_CYC + 2))
		else $error("read cycle ended too early");

endmodule

// *** rtl/asc_consts.svh ***
// Timing figures and pin encodings for the asynchronous SRAM host controller.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ---------------------------------------------------------------------
// Clock
// ---------------------------------------------------------------------
`define ASC_CLK_NS 4

// Least times round up to whole clock cycles.
`define ASC_CYC(ns) (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)

// ---------------------------------------------------------------------
// Device timing in ns, fast grade then slow grade
// ---------------------------------------------------------------------
`define ASC_READ_CYCLE_PERIOD_FAST_NS  45
`define ASC_READ_CYCLE_PERIOD_SLOW_NS  55
`define ASC_ACCESS_FAST_NS             45
`define ASC_ACCESS_SLOW_NS             55
`define ASC_OE_RELEASE_FAST_NS         15
`define ASC_OE_RELEASE_SLOW_NS         20
`define ASC_WRITE_CYCLE_PERIOD_FAST_NS 45
`define ASC_WRITE_CYCLE_PERIOD_SLOW_NS 55
`define ASC_WRITE_PULSE_WIDTH_FAST_NS  35
`define ASC_WRITE_PULSE_WIDTH_SLOW_NS  40
`define ASC_WRITE_ADDRESS_LEAD_FAST_NS 35
`define ASC_WRITE_ADDRESS_LEAD_SLOW_NS 40
`define ASC_WRITE_DATA_SETUP_FAST_NS   20
`define ASC_WRITE_DATA_SETUP_SLOW_NS   25
`define ASC_WRITE_RELEASE_FAST_NS      15
`define ASC_WRITE_RELEASE_SLOW_NS      20

// ---------------------------------------------------------------------
// Pin levels, field positions and widths
// ---------------------------------------------------------------------
`define ASC_EXTRA_ADDRESS_BIT 15
`define ASC_ADDR_W            20
`define ASC_TIMER_W           5
`define ASC_WIDE_LEVEL        1'h1

`endif

// *** rtl/asc_pkg.sv ***
// Types shared by the asynchronous SRAM host controller.
package asc_pkg;

	// -----------------------------------------------------------------
	// Sequencer states
	// -----------------------------------------------------------------
	typedef enum logic [4:0]
	{
		ASC_IDLE   = 5'h01,
		ASC_READ   = 5'h02,
		ASC_WSETUP = 5'h04,
		ASC_WPULSE = 5'h08,
		ASC_WHOLD  = 5'h10
	} asc_state_type;

endpackage

// *** rtl/asc_timer.sv ***
// Loadable down counter that paces the SRAM bus phases.
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_timer
#(
	parameter int WIDTH = `ASC_TIMER_W
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] value,
	// Status
	output logic                  done
);

	typedef struct packed
	{
		logic [WIDTH-1:0] count;
	} asc_timer_state_type;

	asc_timer_state_type s_q;
	asc_timer_state_type s_d;

	always_comb
	begin
		s_d = s_q;
		if (load)
			s_d.count = value;
		else if (s_q.count != '0)
			s_d.count = s_q.count - WIDTH'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign done = (s_q.count == '0);

endmodule

// *** dv/asc_sram_model.sv ***
// Behavioural model of the asynchronous SRAM driven by the host controller.
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_sram_model
#(
	parameter int ACC_NS  = `ASC_ACCESS_FAST_NS,
	parameter int LEAD_NS = `ASC_WRITE_ADDRESS_LEAD_FAST_NS,
	parameter int SD_NS   = `ASC_WRITE_DATA_SETUP_FAST_NS,
	parameter int HZW_NS  = `ASC_WRITE_RELEASE_FAST_NS,
	parameter int CYC_NS  = `ASC_READ_CYCLE_PERIOD_FAST_NS
)
(
	// Host pins
	input  wire logic [19:0] addr_pin,
	input  wire logic        select_low_n,
	input  wire logic        select_high,
	input  wire logic        upper_lane_n,
	input  wire logic        lower_lane_n,
	input  wire logic        write_n,
	input  wire logic        out_en_n,
	input  wire logic        width_sel,
	input  wire logic [15:0] bus_dq,
	input  wire logic [15:0] host_oe,
	// Device drive and count of host timing faults
	output logic [15:0]      dev_dq,
	output logic [15:0]      dev_oe,
	output int               viol_cnt
);
	// ---------------------------------------------------------------
	// Array and timers, stepped every nanosecond
	// ---------------------------------------------------------------
	logic [15:0] mem [int];
	logic [15:0] wbuf, last_dq, w, val, k;
	logic [19:0] waddr, last_a;
	logic [1:0]  lane, wlane;
	logic        sel, x8, wx8, now, rd_ok, v0, v1;
	logic        wact = 1'b0;
	int          sel_t = 0, addr_t = 0, oe_t = 0, we_t = 0;
	int          wlo_t = 0, dat_t = 0;
	int          lt [2] = '{0, 0};

	// Half-nanosecond phase keeps sampling away from the clock edges.
	initial
	begin
		viol_cnt = 0;
		dev_oe = 16'h0000;
		dev_dq = 16'h0000;
		#0.5;
		forever
		begin
			sel = !select_low_n && select_high;
			x8 = !width_sel;
			lane = x8 ? 2'h3 : ~{upper_lane_n, lower_lane_n};
			now = sel && !write_n && |lane;
			if (wact && !now)
			begin
				if (sel_t < LEAD_NS || addr_t < LEAD_NS)
					viol_cnt++;
				if (dat_t < SD_NS || wlo_t <= HZW_NS + SD_NS)
					viol_cnt++;
				if ((wlane[0] && lt[0] < LEAD_NS) || (wlane[1] && lt[1] < LEAD_NS))
					viol_cnt++;
				w = mem.exists(waddr) ? mem[waddr] : 16'h0000;
				k = {{8{wlane[1]}}, {8{wlane[0]}}};
				if (wx8 && wbuf[15])
					w[15:8] = wbuf[7:0];
				else if (wx8)
					w[7:0] = wbuf[7:0];
				else
					w = (wbuf & k) | (w & ~k);
				mem[waddr] = w;
			end
			if (!sel && sel_t > 0 && sel_t < CYC_NS)
				viol_cnt++;
			sel_t = sel ? sel_t + 1 : 0;
			lt[0] = lane[0] ? lt[0] + 1 : 0;
			lt[1] = lane[1] ? lt[1] + 1 : 0;
			addr_t = (addr_pin === last_a) ? addr_t + 1 : 0;
			dat_t = (bus_dq === last_dq) ? dat_t + 1 : 0;
			oe_t = out_en_n ? 0 : oe_t + 1;
			we_t = write_n ? we_t + 1 : 0;
			wlo_t = write_n ? 0 : wlo_t + 1;
			last_a = addr_pin;
			last_dq = bus_dq;
			if (now)
			begin
				wbuf = bus_dq;
				wlane = lane;
				waddr = addr_pin;
				wx8 = x8;
			end
			wact = now;
			rd_ok = sel && !out_en_n && write_n && oe_t >= 5;
			rd_ok = rd_ok && we_t >= 5 && sel_t >= 10;
			w = mem.exists(addr_pin) ? mem[addr_pin] : 16'h0000;
			val = x8 ? {8'h00, bus_dq[15] ? w[15:8] : w[7:0]} : w;
			v0 = sel_t >= ACC_NS && addr_t >= ACC_NS && lt[0] >= ACC_NS;
			v1 = sel_t >= ACC_NS && addr_t >= ACC_NS && lt[1] >= ACC_NS;
			dev_oe[7:0] = {8{rd_ok && lt[0] >= 10}};
			dev_oe[15:8] = {8{rd_ok && lt[1] >= 10 && !x8}};
			if (|dev_oe)
				dev_dq = {v1 ? val[15:8] : ~val[15:8], v0 ? val[7:0] : ~val[7:0]};
			if (|(dev_oe & host_oe))
				viol_cnt++;
			#1;
		end
	end
endmodule

// *** dv/asc_ctrl_tb.sv ***
// Self-checking bench for the asynchronous SRAM host controller.
`timescale 1ns/1ps

module asc_ctrl_tb;
	// ---------------------------------------------------------------
	// Signals, reference array and expected answers
	// ---------------------------------------------------------------
	localparam int LAT = 14;
	logic        clk, rstn, req_valid, req_ready, req_write, wide_mode;
	logic        resp_valid, select_low_n, select_high, upper_lane_n;
	logic        lower_lane_n, write_n, out_en_n, width_sel;
	logic [20:0] req_addr;
	logic [19:0] addr_pin;
	logic [15:0] req_wdata, resp_rdata, dq_in, dq_out, dq_oe, dev_dq, dev_oe;
	logic [1:0]  req_lanes;
	logic [31:0] r;
	logic [15:0] ref_mem [int];
	logic [15:0] exp_q [$], msk_q [$];
	int          tk_q [$];
	int          viol_cnt, n;
	int          bad_count = 0, tests_run = 0, cyc = 0;

	// A line that neither side drives shows the inverse of the device's last driven value.
	assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev_oe & dev_dq)
		| (~dq_oe & ~dev_oe & ~dev_dq);

	asc_ctrl #(.FAST_GRADE(1'b1)) dut_u
	(
		.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_lanes(req_lanes), .wide_mode(wide_mode),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata), .addr_pin(addr_pin),
		.select_low_n(select_low_n), .select_high(select_high),
		.upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n),
		.write_n(write_n), .out_en_n(out_en_n), .width_sel(width_sel),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe)
	);

	asc_sram_model mem_u
	(
		.addr_pin(addr_pin), .select_low_n(select_low_n),
		.select_high(select_high), .upper_lane_n(upper_lane_n),
		.lower_lane_n(lower_lane_n), .write_n(write_n), .out_en_n(out_en_n),
		.width_sel(width_sel), .bus_dq(dq_in), .host_oe(dq_oe),
		.dev_dq(dev_dq), .dev_oe(dev_oe), .viol_cnt(viol_cnt)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
		cyc <= cyc + 1;

	// ---------------------------------------------------------------
	// Checking and request tasks
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic do_req(input logic w, input logic [20:0] a,
		input logic [15:0] d, input logic [1:0] l, input logic m);
		logic [15:0] cur, e, k;
		int          t;
		cur = ref_mem.exists(a[19:0]) ? ref_mem[a[19:0]] : 16'h0000;
		k = {{8{l[1]}}, {8{l[0]}}};
		if (w && m)
			cur = (d & k) | (cur & ~k);
		else if (w && a[20])
			cur[15:8] = d[7:0];
		else if (w)
			cur[7:0] = d[7:0];
		if (w)
			ref_mem[a[19:0]] = cur;
		e = m ? cur : {8'h00, a[20] ? cur[15:8] : cur[7:0]};
		k = w ? 16'h0000 : (m ? k : 16'hffff);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_lanes = l;
		wide_mode = m;
		for (t = 0; t < 40 && req_ready !== 1'b1; t++)
		begin
			@(posedge clk);
			#1;
		end
		if (t == 40)
		begin
			check(1'b0, "request never taken");
			end_of_test();
		end
		@(posedge clk);
		#1;
		exp_q.push_back(e);
		msk_q.push_back(k);
		tk_q.push_back(cyc);
	endtask

	always @(negedge clk)
	begin
		if (rstn === 1'b1 && resp_valid === 1'b1 && exp_q.size() == 0)
			check(1'b0, "answer without request");
		else if (rstn === 1'b1 && resp_valid === 1'b1)
		begin
			check((resp_rdata & msk_q[0]) === (exp_q[0] & msk_q[0]), "data");
			check(cyc - tk_q[0] == LAT, "answer latency");
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
			void'(tk_q.pop_front());
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 21'h000000;
		req_wdata = 16'h0000;
		req_lanes = 2'h0;
		wide_mode = 1'b1;
		r = $urandom(70283);
		repeat (16) @(posedge clk);
		#1;
		check({req_ready, resp_valid, select_low_n, select_high, upper_lane_n,
			lower_lane_n, write_n, out_en_n, width_sel, dq_oe, addr_pin}
			=== {9'h15f, 16'h0000, 20'h00000}, "reset levels");
		rstn = 1'b1;
		@(posedge clk);
		#1;
		do_req(1'b1, 21'h000003, 16'ha55a, 2'h3, 1'b1);
		do_req(1'b0, 21'h000003, 16'h0000, 2'h3, 1'b1);
		do_req(1'b1, 21'h000003, 16'h1234, 2'h0, 1'b1);
		do_req(1'b1, 21'h000003, 16'hbeef, 2'h2, 1'b1);
		do_req(1'b0, 21'h000003, 16'h0000, 2'h3, 1'b1);
		do_req(1'b1, 21'h100003, 16'h0077, 2'h0, 1'b0);
		do_req(1'b0, 21'h100003, 16'h0000, 2'h0, 1'b0);
		do_req(1'b0, 21'h000003, 16'h0000, 2'h1, 1'b1);
		for (int i = 0; i < 300; i++)
		begin
			r = $urandom;
			do_req(r[0], {r[1], 17'h00000, r[4:2]}, r[31:16], r[6:5], r[7] | r[8]);
			if (r[10:9] == 2'h0)
			begin
				req_valid = 1'b0;
				@(posedge clk);
				#1;
			end
		end
		req_valid = 1'b0;
		for (n = 0; n < 100 && exp_q.size() > 0; n++)
			@(posedge clk);
		check(exp_q.size() == 0, "answers missing");
		check(viol_cnt == 0, "bus timing broken");
		end_of_test();
	end
endmodule
